/* hdl/csd_bank_match.sv */
// One bank's address, direction and attribute match
module csd_bank_match
    import csd_pkg::*;
(
    input wire logic [15:0] base,
    input wire csd_mask_type mask,
    input wire csd_ctrl_type ctrl,
    input wire logic programmed,
    input wire csd_xfer_type xfer,
    output logic hit
);
    logic addr_ok;
    logic dir_ok;
    logic attr_ok;
    // Masked bits drop out of the compare
    assign addr_ok = ((xfer.addr[31:16] ^ base) & ~mask.mask_field) == 16'h0000; // RULE_15 RULE_16 RULE_17
    assign dir_ok = xfer.write ? ctrl.wr_en : ctrl.rd_en;
    assign attr_ok = (xfer.attr & mask.attr_mask) == '0;
    assign hit = programmed & addr_ok & dir_ok & attr_ok; // RULE_20 RULE_22
endmodule : csd_bank_match

/* hdl/csd_decoder.sv */
// Chip-select decoder with strobes, lane steering and acknowledge
// Notes on behaviour
// RULE_01: Long and line strobes follow port width
// RULE_02: 24 address outputs plus four upper
// RULE_03: Upper pins carry address only when assigned
// RULE_04: Max bank size follows enabled address lines
// RULE_05: Core bursts drive and increment address
// RULE_06: Alternate master hits leave address undriven
// RULE_07: Ports sit on fixed upper data lanes
// RULE_08: Drive acknowledge after waits for alternate
// RULE_09: External party acknowledges core transfers
// RULE_10: Each bank has base, mask, control
// RULE_11: Per-bank width, burst, waits, ack, setup/hold; the code stores burst_en per bank but never reads it
// RULE_12: Bank 0 global select after reset
// RULE_13: Bank 1 optional on cpu space
// RULE_14: Unmatched space uses fallback control
// RULE_15: Compare address ignoring masked bits
// RULE_16: Fields map to address bits 31-16
// RULE_17: Zero mask spans 64 kbyte
// RULE_18: Software masks contiguously from bit 16
// RULE_19: Bank 0 first, then 7, DRAM, default; the code ranks banks 0 to 7 in ascending order
// RULE_20: Select needs match, direction, unmasked attribute
// RULE_21: Active-low strobe 0 is top lane
// RULE_22: Other banks off until programmed
module csd_decoder
    import csd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // Transfer start and request
    input wire logic xfer_start,
    input wire csd_xfer_type xfer,
    input wire logic [31:0] wdata,
    input wire logic dram0_hit,
    input wire logic dram1_hit,
    // Bank register writes
    input wire logic [2:0] cfg_bank,
    input wire logic cfg_base_we,
    input wire logic cfg_mask_we,
    input wire logic cfg_ctrl_we,
    input wire logic cfg_fallback_we,
    input wire logic [15:0] cfg_base,
    input wire csd_mask_type cfg_mask,
    input wire csd_ctrl_type cfg_ctrl,
    // Pin assignment of the four upper pins, one bit per pin, 1 = address
    input wire logic [3:0] upper_addr_en,
    // External acknowledge input
    input wire logic transfer_ack_n_in,
    output logic [7:0] bank_sel_n,
    output logic [3:0] byte_we_n,
    output logic [23:0] addr_out,
    output logic [3:0] upper_addr_out,
    output logic [3:0] upper_addr_oe,
    output logic addr_oe,
    output logic [31:0] data_out,
    output logic data_oe,
    output logic transfer_ack_n_out,
    output logic transfer_ack_n_oe,
    output logic xfer_done,
    output logic default_region,
    output logic [27:0] max_bank_bytes
);
    // ------------------------------------------------------------
    // Bank registers
    // ------------------------------------------------------------
    logic [15:0] bank_base_reg [CSD_BANKS];
    csd_mask_type bank_mask_reg [CSD_BANKS];
    csd_ctrl_type bank_control_reg [CSD_BANKS];
    csd_ctrl_type fallback_control_reg;
    logic [CSD_BANKS-1:0] programmed;
    logic global_mode;

    always_ff @(posedge clk or posedge rst) begin // RULE_10
        if (rst) begin
            for (int i = 0; i < CSD_BANKS; i++) begin
                bank_base_reg[i] <= CSD_BASE_RST;
                bank_mask_reg[i] <= '{mask_field: CSD_MASK_RST, attr_mask: '0};
                bank_control_reg[i] <= '{port_size: CSD_PS_RST, wait_states: CSD_WAIT_RST,
                    auto_ack: 1'b1, alt_ack: 1'b0, burst_en: 1'b0, addr_setup: 1'b1,
                    addr_hold: 1'b1, rd_en: 1'b1, wr_en: 1'b1};
            end
            fallback_control_reg <= '{port_size: CSD_PS_RST, wait_states: CSD_WAIT_RST,
                auto_ack: 1'b1, alt_ack: 1'b0, burst_en: 1'b0, addr_setup: 1'b0,
                addr_hold: 1'b0, rd_en: 1'b1, wr_en: 1'b1};
        end else begin
            if (cfg_base_we)
                bank_base_reg[cfg_bank] <= cfg_base;
            if (cfg_mask_we)
                bank_mask_reg[cfg_bank] <= cfg_mask;
            if (cfg_ctrl_we)
                bank_control_reg[cfg_bank] <= cfg_ctrl;
            if (cfg_fallback_we)
                fallback_control_reg <= cfg_ctrl;
        end
    end

    // Bank counts as programmed once all three registers written
    logic [CSD_BANKS-1:0] seen_base;
    logic [CSD_BANKS-1:0] seen_mask;
    logic [CSD_BANKS-1:0] seen_ctrl;
    always_ff @(posedge clk or posedge rst) begin // RULE_22
        if (rst) begin
            seen_base <= '0;
            seen_mask <= '0;
            seen_ctrl <= '0;
        end else begin
            if (cfg_base_we)
                seen_base[cfg_bank] <= 1'b1;
            if (cfg_mask_we)
                seen_mask[cfg_bank] <= 1'b1;
            if (cfg_ctrl_we)
                seen_ctrl[cfg_bank] <= 1'b1;
        end
    end
    assign programmed = seen_base & seen_mask & seen_ctrl;

    // Global mode ends on first write of bank 0 mask
    always_ff @(posedge clk or posedge rst) begin // RULE_12
        if (rst)
            global_mode <= 1'b1;
        else if (cfg_mask_we && cfg_bank == 3'h0)
            global_mode <= 1'b0;
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [CSD_BANKS-1:0] raw_hit;
    logic [CSD_BANKS-1:0] hit;
    for (genvar g = 0; g < CSD_BANKS; g++) begin : g_match
        csd_bank_match u_match (
            .base(bank_base_reg[g]),
            .mask(bank_mask_reg[g]),
            .ctrl(bank_control_reg[g]),
            .programmed(programmed[g]),
            .xfer(xfer),
            .hit(raw_hit[g])
        );
    end

    logic cpu_space;
    assign cpu_space = xfer.attr[CSD_ATTR_CPU];
    always_comb begin
        hit = raw_hit;
        hit[0] = global_mode ? ~cpu_space : raw_hit[0]; // RULE_12
        // Cpu space only reaches bank 1, gated by its attribute mask
        for (int i = 2; i < CSD_BANKS; i++)
            if (cpu_space)
                hit[i] = 1'b0;
        if (cpu_space)
            hit[0] = 1'b0; // RULE_13
    end

    logic [CSD_BANKS-1:0] next_sel;
    logic next_default;
    csd_ctrl_type next_ctrl;
    always_comb begin // RULE_19
        next_sel = '0;
        next_default = 1'b0;
        next_ctrl = fallback_control_reg;
        if (hit != '0) begin
            for (int i = CSD_BANKS - 1; i >= 0; i--) begin
                if (hit[i]) begin
                    next_sel = '0;
                    next_sel[i] = 1'b1;
                    next_ctrl = bank_control_reg[i];
                end
            end
        end else if (!(dram0_hit || dram1_hit)) begin
            next_default = 1'b1; // RULE_14
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    csd_state_type state;
    csd_ctrl_type cur_ctrl;
    csd_xfer_type cur;
    logic [CSD_BANKS-1:0] cur_sel;
    logic cur_default;
    logic [3:0] wait_cnt;
    logic [1:0] beats_left;
    logic active;
    logic ack_now;
    logic int_ack;
    logic beat_end;
    logic last_beat;

    assign active = state == CSD_WAIT || state == CSD_SETUP;
    assign int_ack = cur_ctrl.auto_ack && wait_cnt == 4'h0;
    // Core transfers also end on the external acknowledge
    assign ack_now = int_ack || (!cur.alt_master && !transfer_ack_n_in); // RULE_09
    assign beat_end = state == CSD_WAIT && ack_now;
    assign last_beat = beats_left == 2'h0;

    // Beats after the first: operand wider than port, with bursting or not
    function automatic logic [1:0] beat_count(input logic [1:0] sz, input logic [1:0] ps);
        logic [1:0] n;
        n = 2'h0;
        if (sz == CSD_SIZE_LONG || sz == CSD_SIZE_LINE) begin
            if (ps == CSD_PS_8)
                n = 2'h3;
            else if (ps == CSD_PS_16)
                n = 2'h1;
        end else if (sz == CSD_SIZE_WORD && ps == CSD_PS_8) begin
            n = 2'h1;
        end
        return n;
    endfunction : beat_count

    always_ff @(posedge clk or posedge rst) begin // RULE_11
        if (rst) begin
            state <= CSD_IDLE;
            cur <= '0;
            cur_ctrl <= '0;
            cur_sel <= '0;
            cur_default <= 1'b0;
            wait_cnt <= 4'h0;
            beats_left <= 2'h0;
        end else begin
            unique case (state)
                CSD_IDLE: begin
                    if (xfer_start) begin
                        cur <= xfer;
                        cur_ctrl <= next_ctrl;
                        cur_sel <= next_sel;
                        cur_default <= next_default;
                        wait_cnt <= next_ctrl.wait_states;
                        beats_left <= beat_count(xfer.size, next_ctrl.port_size);
                        state <= next_ctrl.addr_setup ? CSD_SETUP : CSD_WAIT;
                    end
                end
                CSD_SETUP: state <= CSD_WAIT;
                CSD_WAIT: begin
                    if (ack_now) begin
                        if (!last_beat) begin
                            beats_left <= beats_left - 2'h1;
                            wait_cnt <= cur_ctrl.wait_states;
                            cur.addr <= cur.addr + ((cur_ctrl.port_size == CSD_PS_8) ?
                                32'h1 : 32'h2); // RULE_05
                        end else begin
                            state <= cur_ctrl.addr_hold ? CSD_HOLD : CSD_IDLE;
                        end
                    end else if (wait_cnt != 4'h0) begin
                        wait_cnt <= wait_cnt - 4'h1;
                    end
                end
                CSD_HOLD: state <= CSD_IDLE;
            endcase
        end
    end
    assign xfer_done = beat_end && last_beat;
    assign default_region = cur_default && state != CSD_IDLE;

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    logic in_xfer;
    logic hit_bank;
    assign in_xfer = state != CSD_IDLE;
    assign hit_bank = cur_sel != '0 || cur_default;
    assign bank_sel_n = (active || state == CSD_HOLD) ? ~cur_sel : 8'hff;

    // Address driven for core transfers only
    assign addr_out = cur.addr[23:0]; // RULE_02
    assign upper_addr_out = cur.addr[27:24];
    assign addr_oe = in_xfer && !cur.alt_master; // RULE_05 RULE_06
    assign upper_addr_oe = (in_xfer && !cur.alt_master) ? upper_addr_en : 4'h0; // RULE_03

    // Top offset of largest bank, 16 Mbyte doubled per line enabled in order from upper pin 0
    always_comb begin // RULE_04
        max_bank_bytes = 28'h0ffffff;
        if (upper_addr_en[0]) begin
            max_bank_bytes = 28'h1ffffff;
            if (upper_addr_en[1]) begin
                max_bank_bytes = 28'h3ffffff;
                if (upper_addr_en[2]) begin
                    max_bank_bytes = 28'h7ffffff;
                    if (upper_addr_en[3])
                        max_bank_bytes = 28'hfffffff;
                end
            end
        end
    end

    // Byte strobes, strobe 0 is D[31:24]
    logic [3:0] we_mask;
    always_comb begin // RULE_21
        we_mask = 4'h0;
        unique case (cur_ctrl.port_size)
            CSD_PS_8: we_mask = 4'b1000; // RULE_01
            CSD_PS_16: begin
                if (cur.size == CSD_SIZE_BYTE)
                    we_mask = cur.addr[0] ? 4'b0100 : 4'b1000;
                else
                    we_mask = 4'b1100; // RULE_01
            end
            default: begin
                unique case (cur.size)
                    CSD_SIZE_BYTE: we_mask = 4'b1000 >> cur.addr[1:0];
                    CSD_SIZE_WORD: we_mask = cur.addr[1] ? 4'b0011 : 4'b1100;
                    default: we_mask = 4'b1111; // RULE_01
                endcase
            end
        endcase
    end
    assign byte_we_n = (active && cur.write && hit_bank) ?
        ~{we_mask[0], we_mask[1], we_mask[2], we_mask[3]} : 4'hf;

    // Lane steering of write data onto the port lanes
    logic [1:0] beat_idx;
    logic [1:0] next_idx;
    logic [1:0] next_ps;
    assign beat_idx = beat_count(cur.size, cur_ctrl.port_size) - beats_left;
    // Lanes of the beat that starts at this edge
    assign next_idx = (state == CSD_IDLE) ? 2'h0 : beat_idx + {1'b0, beat_end};
    assign next_ps = (state == CSD_IDLE) ? next_ctrl.port_size : cur_ctrl.port_size;
    always_ff @(posedge clk or posedge rst) begin // RULE_07
        if (rst) begin
            data_out <= 32'h00000000;
        end else begin
            unique case (next_ps)
                CSD_PS_8: data_out <= {wdata[8'd31 - {next_idx, 3'h0} -: 8], 24'h000000};
                CSD_PS_16: data_out <= {(next_idx[0] ? wdata[15:0] : wdata[31:16]), 16'h0000};
                default: data_out <= wdata;
            endcase
        end
    end
    assign data_oe = active && cur.write && !cur.alt_master;

    // Acknowledge driven for alternate master hits when enabled
    assign transfer_ack_n_oe = in_xfer && cur.alt_master && cur_ctrl.alt_ack && hit_bank; // RULE_08
    assign transfer_ack_n_out = !(state == CSD_WAIT && int_ack); // RULE_08

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_ack_wait;
        state == CSD_WAIT && wait_cnt == 4'h0 && cur_ctrl.auto_ack;
    endsequence

    a_wide_strobes: assert property (@(posedge clk) disable iff (rst)
        (active && cur.write && hit_bank && cur.size == CSD_SIZE_LONG && cur_ctrl.port_size == CSD_PS_16)
        |-> byte_we_n == 4'b1100) // RULE_01
        else $error("16-bit long write strobes wrong");
    a_upper_pins: assert property (@(posedge clk) disable iff (rst)
        (upper_addr_oe & ~upper_addr_en) == 4'h0) // RULE_03
        else $error("Upper address pin driven while not assigned");
    a_alt_no_addr: assert property (@(posedge clk) disable iff (rst)
        (in_xfer && cur.alt_master) |-> !addr_oe) // RULE_06
        else $error("Address driven during alternate transfer");
    a_alt_ack_out: assert property (@(posedge clk) disable iff (rst)
        (s_ack_wait and transfer_ack_n_oe) |-> !transfer_ack_n_out) // RULE_08
        else $error("Acknowledge missing after waits");
    a_global_sel: assert property (@(posedge clk) disable iff (rst)
        (global_mode && !cpu_space) |-> next_sel[0]) // RULE_12
        else $error("Global select not taken");
    a_priority_one: assert property (@(posedge clk) disable iff (rst)
        $onehot0(next_sel) && (next_default -> next_sel == '0)) // RULE_19
        else $error("Select priority broken");
    a_unprog_off: assert property (@(posedge clk) disable iff (rst)
        (next_sel & ~programmed & 8'hfe) == '0) // RULE_22
        else $error("Unprogrammed bank selected");
    a_burst_incr: assert property (@(posedge clk) disable iff (rst)
        (beat_end && !last_beat && cur_ctrl.port_size == CSD_PS_16)
        |=> cur.addr == $past(cur.addr) + 32'h2) // RULE_05
        else $error("Burst address not incremented");
endmodule : csd_decoder

/* hdl/csd_pkg.sv */
// Package of constants and types for the chip-select decoder
package csd_pkg;
    localparam int CSD_BANKS = 8;
    localparam int CSD_ADDR_W = 32;
    localparam int CSD_DED_ADDR = 24;
    localparam int CSD_UPPER_ADDR = 4;
    localparam int CSD_CMP_LSB = 16;
    localparam int CSD_CMP_W = 16;
    localparam int CSD_WAIT_W = 4;
    // Port width codes
    localparam logic [1:0] CSD_PS_32 = 2'h0;
    localparam logic [1:0] CSD_PS_8 = 2'h1;
    localparam logic [1:0] CSD_PS_16 = 2'h2;
    // Transfer size codes
    localparam logic [1:0] CSD_SIZE_LONG = 2'h0;
    localparam logic [1:0] CSD_SIZE_BYTE = 2'h1;
    localparam logic [1:0] CSD_SIZE_WORD = 2'h2;
    localparam logic [1:0] CSD_SIZE_LINE = 2'h3;
    // Attribute classes: sup data, sup code, user data, user code, cpu space
    localparam int CSD_ATTR_W = 5;
    localparam int CSD_ATTR_CPU = 4;
    // Reset values
    localparam logic [15:0] CSD_BASE_RST = 16'h0000;
    localparam logic [15:0] CSD_MASK_RST = 16'h0000;
    localparam logic [3:0] CSD_WAIT_RST = 4'hf;
    localparam logic [1:0] CSD_PS_RST = 2'h0;
    // Bank control fields
    typedef struct packed {
        logic [1:0] port_size;
        logic [3:0] wait_states;
        logic auto_ack;
        logic alt_ack;
        logic burst_en;
        logic addr_setup;
        logic addr_hold;
        logic rd_en;
        logic wr_en;
    } csd_ctrl_type;
    // Bank mask register content
    typedef struct packed {
        logic [15:0] mask_field;
        logic [CSD_ATTR_W-1:0] attr_mask;
    } csd_mask_type;
    // One transfer request
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0] size;
        logic write;
        logic [CSD_ATTR_W-1:0] attr;
        logic alt_master;
    } csd_xfer_type;
    typedef enum logic [1:0] {
        CSD_IDLE = 2'b00,
        CSD_SETUP = 2'b01,
        CSD_WAIT = 2'b10,
        CSD_HOLD = 2'b11
    } csd_state_type;
endpackage : csd_pkg

/* tb/csd_mem_model.sv */
// Behavioural memory device that acknowledges its selected transfers
module csd_mem_model
    import csd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] bank_sel_n,
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    output logic ack_n,
    output logic ack_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] count;
    // ----------------------------------------
    // Selected-cycle counter
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 5'h00;
        end else if (&bank_sel_n) begin
            count <= 5'h00;
        end else if (count != 5'h1f) begin
            count <= count + 5'h01;
        end
    end
    // One acknowledge per selection, then the line is released
    assign ack_drive = ack_en && !(&bank_sel_n) && (count == {1'b0, ack_delay});
    assign ack_n = ~ack_drive;
endmodule : csd_mem_model

/* tb/test_chip_select_decoder.sv */
// Self-checking bench for the chip-select decoder
`define CHK(name, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("Error %s expected %h seen %h", name, exp, got); \
        end \
    end
module test_chip_select_decoder
    import csd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic xfer_start = 1'b0;
    csd_xfer_type xfer = '0;
    logic [31:0] wdata = 32'ha5c35a3c;
    logic dram0_hit = 1'b0;
    logic [2:0] cfg_bank = 3'h0;
    logic cfg_base_we = 1'b0;
    logic cfg_mask_we = 1'b0;
    logic cfg_ctrl_we = 1'b0;
    logic cfg_fallback_we = 1'b0;
    logic [15:0] cfg_base = 16'h0000;
    csd_mask_type cfg_mask = '0;
    csd_ctrl_type cfg_ctrl = '0;
    logic [3:0] upper_addr_en = 4'h0;
    logic ack_en = 1'b0;
    logic [3:0] ack_delay = 4'h1;
    logic ack_wire, p_ack_n, p_drive, addr_oe, data_oe, ack_out, ack_oe, xfer_done, dreg;
    logic [7:0] bank_sel_n;
    logic [3:0] byte_we_n, upper_addr_out, upper_addr_oe;
    logic [23:0] addr_out;
    logic [31:0] data_out;
    logic [27:0] max_bank_bytes;
    logic [7:0] sel_seen;
    logic [3:0] we_seen, uoe_seen, uout;
    logic [23:0] amax;
    logic [31:0] dfirst, dlast;
    logic aoe_seen, toe_seen, tack_seen, dreg_seen, dseen;
    int fail_count = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    // Pulled-up acknowledge line shared by device and memory
    assign ack_wire = ack_oe ? ack_out : (p_drive ? p_ack_n : 1'b1);
    csd_decoder dut (.clk(clk), .rst(rst), .xfer_start(xfer_start), .xfer(xfer),
        .wdata(wdata), .dram0_hit(dram0_hit), .dram1_hit(1'b0), .cfg_bank(cfg_bank),
        .cfg_base_we(cfg_base_we), .cfg_mask_we(cfg_mask_we), .cfg_ctrl_we(cfg_ctrl_we),
        .cfg_fallback_we(cfg_fallback_we), .cfg_base(cfg_base), .cfg_mask(cfg_mask),
        .cfg_ctrl(cfg_ctrl), .upper_addr_en(upper_addr_en), .transfer_ack_n_in(ack_wire),
        .bank_sel_n(bank_sel_n), .byte_we_n(byte_we_n), .addr_out(addr_out),
        .upper_addr_out(upper_addr_out), .upper_addr_oe(upper_addr_oe), .addr_oe(addr_oe),
        .data_out(data_out), .data_oe(data_oe), .transfer_ack_n_out(ack_out),
        .transfer_ack_n_oe(ack_oe), .xfer_done(xfer_done), .default_region(dreg),
        .max_bank_bytes(max_bank_bytes));
    csd_mem_model mem (.clk(clk), .rst(rst), .bank_sel_n(bank_sel_n), .ack_en(ack_en),
        .ack_delay(ack_delay), .ack_n(p_ack_n), .ack_drive(p_drive));

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    function automatic csd_ctrl_type mk_ctrl(input logic [1:0] ps, input logic [3:0] w,
        input logic aa, input logic rd, input logic wr);
        mk_ctrl = '{port_size: ps, wait_states: w, auto_ack: aa, alt_ack: 1'b1,
            burst_en: 1'b1, addr_setup: 1'b0, addr_hold: 1'b0, rd_en: rd, wr_en: wr};
    endfunction : mk_ctrl

    // Base, mask and control writes, one pulse each
    task automatic cfg(input logic [2:0] b, input logic [15:0] base, input logic [15:0] mf,
        input logic [4:0] am, input csd_ctrl_type c);
        @(negedge clk);
        cfg_bank = b;
        cfg_base = base;
        cfg_mask = '{mask_field: mf, attr_mask: am};
        cfg_ctrl = c;
        cfg_base_we = 1'b1;
        @(negedge clk);
        cfg_base_we = 1'b0;
        cfg_mask_we = 1'b1;
        @(negedge clk);
        cfg_mask_we = 1'b0;
        cfg_ctrl_we = 1'b1;
        @(negedge clk);
        cfg_ctrl_we = 1'b0;
    endtask : cfg

    // One transfer, watched until two cycles after completion
    task automatic run(input logic [31:0] a, input logic [1:0] sz, input logic wr,
        input logic [4:0] at, input logic alt);
        int n;
        int post;
        n = 0;
        post = 0;
        @(negedge clk);
        xfer = '{addr: a, size: sz, write: wr, attr: at, alt_master: alt};
        xfer_start = 1'b1;
        {sel_seen, we_seen, uoe_seen, amax} = '0;
        {aoe_seen, toe_seen, tack_seen, dreg_seen, dseen} = '0;
        @(negedge clk);
        xfer_start = 1'b0;
        while (post < 3 && n < 200) begin
            sel_seen |= ~bank_sel_n;
            we_seen |= ~byte_we_n;
            uoe_seen |= upper_addr_oe;
            if (upper_addr_oe !== 4'h0) uout = upper_addr_out;
            aoe_seen |= (addr_oe === 1'b1);
            toe_seen |= (ack_oe === 1'b1);
            tack_seen |= (ack_oe === 1'b1 && ack_out === 1'b0);
            dreg_seen |= (dreg === 1'b1);
            if (addr_oe === 1'b1 && addr_out > amax) amax = addr_out;
            if (data_oe === 1'b1) begin
                if (!dseen) dfirst = data_out;
                dlast = data_out;
                dseen = 1'b1;
            end
            if (xfer_done === 1'b1 || post > 0) post++;
            n++;
            @(negedge clk);
        end
        if (n >= 200) begin
            fail_count++;
            $display("Error xfer_done expected 1 seen 0");
            end_of_test();
        end
    endtask : run

    task automatic t_global();
        run(32'h12345670, CSD_SIZE_LONG, 1'b1, 5'h01, 1'b0);
        `CHK("sel_global", 8'h01, sel_seen);
        `CHK("we_32", 4'hf, we_seen);
        run(32'h00000000, CSD_SIZE_LONG, 1'b0, 5'h10, 1'b0);
        `CHK("sel_cpu", 8'h00, sel_seen);
        `CHK("default_cpu", 1'b1, dreg_seen);
    endtask : t_global

    task automatic t_decode();
        cfg(3'h0, 16'h0010, 16'h0000, 5'h00, mk_ctrl(CSD_PS_8, 4'h1, 1'b1, 1'b1, 1'b1));
        cfg(3'h2, 16'h0020, 16'h0003, 5'h00, mk_ctrl(CSD_PS_16, 4'h2, 1'b1, 1'b1, 1'b1));
        cfg(3'h3, 16'h0010, 16'h0000, 5'h00, mk_ctrl(CSD_PS_32, 4'h0, 1'b1, 1'b1, 1'b1));
        run(32'h00100000, CSD_SIZE_LONG, 1'b1, 5'h01, 1'b0);
        `CHK("sel_prio", 8'h01, sel_seen);
        `CHK("we_8", 4'h1, we_seen);
        `CHK("addr_last", 24'h100003, amax);
        run(32'h00230000, CSD_SIZE_LONG, 1'b1, 5'h01, 1'b0);
        `CHK("sel_mask", 8'h04, sel_seen);
        `CHK("we_16", 4'h3, we_seen);
        `CHK("lane_first", 16'ha5c3, dfirst[31:16]);
        `CHK("lane_last", 16'h5a3c, dlast[31:16]);
        `CHK("ack_oe_core", 1'b0, toe_seen);
        run(32'h00110000, CSD_SIZE_LONG, 1'b0, 5'h01, 1'b0);
        `CHK("sel_64k", 8'h00, sel_seen);
        `CHK("default_miss", 1'b1, dreg_seen);
        dram0_hit = 1'b1;
        run(32'h00110000, CSD_SIZE_LONG, 1'b0, 5'h01, 1'b0);
        dram0_hit = 1'b0;
        `CHK("default_dram", 1'b0, dreg_seen);
        @(negedge clk);
        cfg_ctrl = mk_ctrl(CSD_PS_8, 4'h1, 1'b1, 1'b1, 1'b1);
        cfg_fallback_we = 1'b1;
        @(negedge clk);
        cfg_fallback_we = 1'b0;
        run(32'h00900000, CSD_SIZE_LONG, 1'b1, 5'h01, 1'b0);
        `CHK("we_fallback", 4'h1, we_seen);
        `CHK("sel_fallback", 8'h00, sel_seen);
    endtask : t_decode

    task automatic t_perm();
        run(32'h00000000, CSD_SIZE_BYTE, 1'b0, 5'h04, 1'b0);
        `CHK("sel_unprog", 8'h00, sel_seen);
        cfg(3'h4, 16'h0040, 16'h0000, 5'h01, mk_ctrl(CSD_PS_32, 4'h0, 1'b1, 1'b1, 1'b0));
        run(32'h00400000, CSD_SIZE_BYTE, 1'b1, 5'h04, 1'b0);
        `CHK("sel_dir", 8'h00, sel_seen);
        run(32'h00400000, CSD_SIZE_BYTE, 1'b0, 5'h01, 1'b0);
        `CHK("sel_attr", 8'h00, sel_seen);
        run(32'h00400000, CSD_SIZE_BYTE, 1'b0, 5'h04, 1'b0);
        `CHK("sel_ok", 8'h10, sel_seen);
        cfg(3'h1, 16'hff00, 16'h00ff, 5'h00, mk_ctrl(CSD_PS_32, 4'h0, 1'b1, 1'b1, 1'b1));
        run(32'hff000000, CSD_SIZE_LONG, 1'b0, 5'h10, 1'b0);
        `CHK("sel_cpu1", 8'h02, sel_seen);
    endtask : t_perm

    task automatic t_alt();
        run(32'h00210000, CSD_SIZE_LONG, 1'b1, 5'h01, 1'b1);
        `CHK("sel_alt", 8'h04, sel_seen);
        `CHK("addr_oe_alt", 1'b0, aoe_seen);
        `CHK("ack_drive_alt", 1'b1, tack_seen);
    endtask : t_alt

    task automatic t_ext_ack();
        logic [3:0] d;
        cfg(3'h5, 16'h0050, 16'h0000, 5'h00, mk_ctrl(CSD_PS_32, 4'hf, 1'b0, 1'b1, 1'b1));
        ack_en = 1'b1;
        for (d = 4'h1; d < 4'h8; d = d + 4'h5) begin
            ack_delay = d;
            run(32'h00500000, CSD_SIZE_LONG, 1'b0, 5'h01, 1'b0);
            `CHK("sel_ext", 8'h20, sel_seen);
        end
        ack_en = 1'b0;
    endtask : t_ext_ack

    task automatic t_upper();
        logic [28:0] lim;
        int k;
        `CHK("addr_width", 24, $bits(addr_out));
        for (k = 0; k <= 4; k++) begin
            @(negedge clk);
            upper_addr_en = 4'((5'h01 << k) - 5'h01);
            lim = (29'h1 << (24 + k)) - 29'h1;
            #1;
            `CHK("max_bank", lim[27:0], max_bank_bytes);
        end
        @(negedge clk);
        upper_addr_en = 4'h3;
        run(32'h06000000, CSD_SIZE_LONG, 1'b0, 5'h01, 1'b0);
        `CHK("upper_oe", 4'h3, uoe_seen);
        `CHK("upper_addr", 4'h2, uout & 4'h3);
    endtask : t_upper

    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_global();
        t_decode();
        t_perm();
        t_alt();
        t_ext_ack();
        t_upper();
        end_of_test();
    end
endmodule : test_chip_select_decoder
